// [hw/eeprom_ctrl.sv]
// Host controller driving a byte-alterable memory through its pins.
// Assumes an external supply switch and high-voltage gate switch on pins.
`timescale 1ns/10ps
module eeprom_ctrl
#(
  parameter int PULSE_CYC = eeprom_ctrl_pkg::PULSE_NOM_CYC,
  parameter int CHIP_ERASE_CYC = eeprom_ctrl_pkg::PULSE_NOM_CYC,
  parameter logic USE_WAIT = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [1:0] op_i,
  input wire logic [eeprom_ctrl_pkg::ADDR_W-1:0] addr_i,
  input wire logic [eeprom_ctrl_pkg::DATA_W-1:0] wdata_i,
  output logic ready_o,
  output logic busy_o,
  output logic [eeprom_ctrl_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic done_o,
  output logic [eeprom_ctrl_pkg::ADDR_W-1:0] mem_addr_o,
  input wire logic [eeprom_ctrl_pkg::DATA_W-1:0] mem_data_i,
  output logic [eeprom_ctrl_pkg::DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_o,
  output logic select_n_o,
  output logic gate_n_o,
  output logic gate_hv_o,
  output logic prog_supply_o
);
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h2;
  localparam logic [1:0] OP_CHIP = 2'h3;
  localparam int TW = eeprom_ctrl_pkg::TIMER_W;
  // Timer load for a pulse of cyc cycles; capped above, short values raised to 2.
  function automatic logic [TW-1:0] clamp_pulse(input int cyc);
    int c;
    c = cyc;
    if (c < 2)
      c = 2;
    if (c > eeprom_ctrl_pkg::PULSE_MAX_CYC)
      c = eeprom_ctrl_pkg::PULSE_MAX_CYC;
    return TW'(c - 1);
  endfunction : clamp_pulse
  localparam logic [TW-1:0] PULSE_LEN = clamp_pulse(PULSE_CYC);
  localparam logic [TW-1:0] CHIP_LEN = clamp_pulse(CHIP_ERASE_CYC);
  eeprom_ctrl_pkg::state_t state;
  eeprom_ctrl_pkg::state_t next_state;
  logic busy;
  logic next_busy;
  logic [eeprom_ctrl_pkg::ADDR_W-1:0] addr;
  logic [eeprom_ctrl_pkg::ADDR_W-1:0] next_addr;
  logic [eeprom_ctrl_pkg::DATA_W-1:0] wdata;
  logic [eeprom_ctrl_pkg::DATA_W-1:0] next_wdata;
  logic [eeprom_ctrl_pkg::DATA_W-1:0] drive;
  logic [eeprom_ctrl_pkg::DATA_W-1:0] next_drive;
  logic [eeprom_ctrl_pkg::DATA_W-1:0] rdata;
  logic [eeprom_ctrl_pkg::DATA_W-1:0] next_rdata;
  logic erase_phase;
  logic next_erase_phase;
  logic with_write;
  logic next_with_write;
  logic sel_n;
  logic next_sel_n;
  logic gate_n;
  logic next_gate_n;
  logic gate_hv;
  logic next_gate_hv;
  logic vpp;
  logic next_vpp;
  logic doe;
  logic next_doe;
  logic rvalid;
  logic next_rvalid;
  logic done;
  logic next_done;
  logic ready;
  logic next_ready;
  logic [7:0] wait_cnt;
  logic [7:0] next_wait_cnt;
  logic [eeprom_ctrl_pkg::DATA_W-1:0] din_meta;
  logic [eeprom_ctrl_pkg::DATA_W-1:0] din_sync;
  pulse_timer_if tif ();
  pulse_timer u_timer
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tif(tif)
  );
  always_comb
  begin
    next_state = state;
    next_addr = addr;
    next_wdata = wdata;
    next_drive = drive;
    next_rdata = rdata;
    next_erase_phase = erase_phase;
    next_with_write = with_write;
    next_sel_n = sel_n;
    next_gate_n = gate_n;
    next_gate_hv = gate_hv;
    next_vpp = vpp;
    next_doe = doe;
    next_rvalid = 1'b0;
    next_done = 1'b0;
    next_ready = ready;
    next_wait_cnt = wait_cnt;
    tif.start = 1'b0;
    tif.count = PULSE_LEN;
    if (wait_cnt != 8'h00)
      next_wait_cnt = wait_cnt - 8'h01;
    case (state)
      eeprom_ctrl_pkg::ST_IDLE:
      begin
        if (req_i)
        begin
          next_addr = addr_i;
          next_wdata = wdata_i;
          next_ready = 1'b0;
          next_sel_n = 1'b0;
          case (op_i)
            OP_READ:
            begin
              next_wait_cnt = 8'(eeprom_ctrl_pkg::ACCESS_CYC
                - eeprom_ctrl_pkg::GATE_CYC);
              next_state = eeprom_ctrl_pkg::ST_RD_SETUP;
            end
            OP_CHIP:
            begin
              next_drive = eeprom_ctrl_pkg::ERASED_BYTE;
              next_doe = 1'b1;
              next_wait_cnt = 8'(eeprom_ctrl_pkg::SETUP_CYC);
              next_state = eeprom_ctrl_pkg::ST_CE_SETUP;
            end
            default:
            begin
              next_drive = eeprom_ctrl_pkg::ERASED_BYTE;
              next_doe = 1'b1;
              next_erase_phase = 1'b1;
              next_with_write = (op_i == OP_WRITE);
              next_wait_cnt = 8'(eeprom_ctrl_pkg::SETUP_CYC);
              next_state = eeprom_ctrl_pkg::ST_WR_SETUP;
            end
          endcase
          if (!USE_WAIT && op_i != OP_READ)
            next_ready = 1'b1;
        end
        else
          next_ready = 1'b1;
      end
      eeprom_ctrl_pkg::ST_RD_SETUP:
      begin
        if (wait_cnt == 8'h00)
        begin
          next_gate_n = 1'b0;
          next_wait_cnt = 8'(eeprom_ctrl_pkg::GATE_CYC + 2);
          next_state = eeprom_ctrl_pkg::ST_RD_WAIT;
        end
      end
      eeprom_ctrl_pkg::ST_RD_WAIT:
      begin
        // sample with select and gate low
        if (wait_cnt == 8'h00)
        begin
          next_rdata = din_sync;
          next_rvalid = 1'b1;
          next_gate_n = 1'b1;
          next_sel_n = 1'b1;
          next_wait_cnt = 8'(eeprom_ctrl_pkg::FLOAT_CYC);
          next_state = eeprom_ctrl_pkg::ST_RD_FLOAT;
        end
      end
      eeprom_ctrl_pkg::ST_RD_FLOAT:
      begin
        if (wait_cnt == 8'h00)
        begin
          next_ready = 1'b1;
          next_state = eeprom_ctrl_pkg::ST_IDLE;
        end
      end
      eeprom_ctrl_pkg::ST_WR_SETUP:
      begin
        next_gate_n = 1'b1;
        if (wait_cnt == 8'h00)
        begin
          next_vpp = 1'b1;
          tif.start = 1'b1;
          tif.count = PULSE_LEN;
          next_state = eeprom_ctrl_pkg::ST_WR_PULSE;
        end
      end
      eeprom_ctrl_pkg::ST_WR_PULSE:
      begin
        if (tif.done)
        begin
          next_vpp = 1'b0;
          next_wait_cnt = 8'(eeprom_ctrl_pkg::HOLD_CYC);
          next_state = eeprom_ctrl_pkg::ST_WR_HOLD;
        end
      end
      eeprom_ctrl_pkg::ST_WR_HOLD:
      begin
        if (wait_cnt == 8'h00)
        begin
          if (erase_phase && with_write)
          begin
            next_erase_phase = 1'b0;
            next_drive = wdata;
            next_wait_cnt = 8'(eeprom_ctrl_pkg::SETUP_CYC);
            next_state = eeprom_ctrl_pkg::ST_WR_SETUP;
          end
          else
          begin
            next_erase_phase = 1'b0;
            next_doe = 1'b0;
            next_sel_n = 1'b1;
            next_done = 1'b1;
            next_ready = 1'b1;
            next_state = eeprom_ctrl_pkg::ST_IDLE;
          end
        end
      end
      eeprom_ctrl_pkg::ST_CE_SETUP:
      begin
        if (wait_cnt == 8'h00)
        begin
          next_gate_hv = 1'b1;
          next_vpp = 1'b1;
          tif.start = 1'b1;
          tif.count = CHIP_LEN;
          next_state = eeprom_ctrl_pkg::ST_CE_PULSE;
        end
      end
      eeprom_ctrl_pkg::ST_CE_PULSE:
      begin
        if (tif.done)
        begin
          next_vpp = 1'b0;
          next_wait_cnt = 8'(eeprom_ctrl_pkg::HOLD_CYC);
          next_state = eeprom_ctrl_pkg::ST_CE_HOLD;
        end
      end
      eeprom_ctrl_pkg::ST_CE_HOLD:
      begin
        if (wait_cnt == 8'h00)
        begin
          next_gate_hv = 1'b0;
          next_doe = 1'b0;
          next_sel_n = 1'b1;
          next_done = 1'b1;
          next_ready = 1'b1;
          next_state = eeprom_ctrl_pkg::ST_IDLE;
        end
      end
      default:
        next_state = eeprom_ctrl_pkg::ST_IDLE;
    endcase
    next_busy = (next_state != eeprom_ctrl_pkg::ST_IDLE);
  end
  always_ff @(posedge clk_i)
  begin
    din_meta <= mem_data_i;
    din_sync <= din_meta;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= eeprom_ctrl_pkg::ST_IDLE;
      addr <= '0;
      wdata <= '0;
      drive <= '0;
      rdata <= '0;
      erase_phase <= 1'b0;
      with_write <= 1'b0;
      sel_n <= 1'b1;
      gate_n <= 1'b1;
      gate_hv <= 1'b0;
      vpp <= 1'b0;
      doe <= 1'b0;
      rvalid <= 1'b0;
      done <= 1'b0;
      ready <= 1'b0;
      wait_cnt <= 8'h00;
      busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      addr <= next_addr;
      wdata <= next_wdata;
      drive <= next_drive;
      rdata <= next_rdata;
      erase_phase <= next_erase_phase;
      with_write <= next_with_write;
      sel_n <= next_sel_n;
      gate_n <= next_gate_n;
      gate_hv <= next_gate_hv;
      vpp <= next_vpp;
      doe <= next_doe;
      rvalid <= next_rvalid;
      done <= next_done;
      ready <= next_ready;
      wait_cnt <= next_wait_cnt;
      busy <= next_busy;
    end
  end
  assign ready_o = ready;
  assign busy_o = busy;
  assign rdata_o = rdata;
  assign rvalid_o = rvalid;
  assign done_o = done;
  assign mem_addr_o = addr;
  assign mem_data_o = drive;
  assign mem_data_oe_o = doe;
  assign select_n_o = sel_n;
  assign gate_n_o = gate_n;
  assign gate_hv_o = gate_hv;
  assign prog_supply_o = vpp;
endmodule : eeprom_ctrl

// [hw/eeprom_ctrl_pkg.sv]
// Constants and types for the byte-alterable nonvolatile memory controller.
// Assumes a 100 MHz clock and one memory array on a shared programming line.
package eeprom_ctrl_pkg;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_PS = 10000;
  localparam int PULSE_MIN_US = 9000;
  localparam int PULSE_MAX_US = 70000;
  localparam int PULSE_NOM_US = 10000;
  localparam int ACCESS_NS = 250;
  localparam int GATE_NS = 100;
  localparam int FLOAT_NS = 80;
  localparam int SETUP_NS = 150;
  localparam int HOLD_NS = 50;
  localparam int PULSE_MIN_CYC = PULSE_MIN_US * (1000000 / CLK_PERIOD_PS);
  localparam int PULSE_MAX_CYC = PULSE_MAX_US * 100;
  localparam int PULSE_NOM_CYC = PULSE_NOM_US * 100;
  localparam int ACCESS_CYC = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int GATE_CYC = (GATE_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int FLOAT_CYC = (FLOAT_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int SETUP_CYC = (SETUP_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int HOLD_CYC = (HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  localparam int TIMER_W = 24;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h0,
    ST_RD_SETUP = 4'h1,
    ST_RD_WAIT = 4'h2,
    ST_RD_FLOAT = 4'h3,
    ST_WR_SETUP = 4'h4,
    ST_WR_PULSE = 4'h5,
    ST_WR_HOLD = 4'h6,
    ST_CE_SETUP = 4'h7,
    ST_CE_PULSE = 4'h8,
    ST_CE_HOLD = 4'h9
  } state_t;
endpackage : eeprom_ctrl_pkg

// [hw/pulse_timer.sv]
// Down-counting delay timer with one-cycle done pulse.
// Assumes start is a single-cycle pulse with count of at least one.
`timescale 1ns/10ps
module pulse_timer
(
  input wire logic clk_i,
  input wire logic rst_i,
  pulse_timer_if.timer tif
);
  logic [eeprom_ctrl_pkg::TIMER_W-1:0] remain;
  logic [eeprom_ctrl_pkg::TIMER_W-1:0] next_remain;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;

  always_comb
  begin
    next_remain = remain;
    next_busy = busy;
    next_done = 1'b0;
    if (tif.start)
    begin
      next_remain = tif.count;
      next_busy = 1'b1;
    end
    else if (busy)
    begin
      if (remain <= 1)
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
      else
      begin
        next_remain = remain - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remain <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      remain <= next_remain;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign tif.done = done;
endmodule : pulse_timer

// [hw/pulse_timer_if.sv]
// Carrier between the sequencer and its pulse timer.
// Assumes both ends share clk_i.
`timescale 1ns/10ps
interface pulse_timer_if;
  logic start;
  logic [eeprom_ctrl_pkg::TIMER_W-1:0] count;
  logic done;
  modport ctrl
  (
    output start,
    output count,
    input done
  );
  modport timer
  (
    input start,
    input count,
    output done
  );
endinterface : pulse_timer_if

// [verification/eeprom_ctrl_chk.sv]
// Pin-level assertions for the memory controller.
// Assumes binding to eeprom_ctrl; sees only its ports.
`timescale 1ns/10ps
module eeprom_ctrl_chk
#(
  parameter int PULSE_CYC = 1,
  parameter int CHIP_ERASE_CYC = 1,
  parameter logic USE_WAIT = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [1:0] op_i,
  input wire logic [10:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic ready_o,
  input wire logic busy_o,
  input wire logic rvalid_o,
  input wire logic done_o,
  input wire logic [10:0] mem_addr_o,
  input wire logic [7:0] mem_data_o,
  input wire logic mem_data_oe_o,
  input wire logic select_n_o,
  input wire logic gate_n_o,
  input wire logic gate_hv_o,
  input wire logic prog_supply_o
);
  logic [1:0] op_q;
  logic [1:0] falls;
  logic [10:0] addr_q;
  logic [7:0] wdata_q;
  int pcnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_q <= 2'h0;
      falls <= 2'h0;
      pcnt <= 0;
    end
    else
    begin
      if ($rose(prog_supply_o))
        pcnt <= 1;
      else if (prog_supply_o)
        pcnt <= pcnt + 1;
      if (req_i && !busy_o)
      begin
        op_q <= op_i;
        addr_q <= addr_i;
        wdata_q <= wdata_i;
        falls <= 2'h0;
      end
      else if ($fell(prog_supply_o))
        falls <= falls + 2'h1;
    end
  end
  sequence s_pulse_end;
    prog_supply_o ##1 !prog_supply_o;
  endsequence
  sequence s_second;
    prog_supply_o && falls == 2'h1;
  endsequence
  a_pulse_min: assert property (s_pulse_end |-> gate_hv_o ||
    pcnt == PULSE_CYC) else $error("pulse length wrong");
  a_chip_len: assert property (s_pulse_end |-> !gate_hv_o ||
    pcnt == CHIP_ERASE_CYC) else $error("chip erase length wrong");
  a_pulse_max: assert property (pcnt <= eeprom_ctrl_pkg::PULSE_MAX_CYC)
    else $error("pulse too long");
  a_erase_first: assert property (prog_supply_o && falls == 2'h0 |->
    mem_data_o == 8'hFF && mem_data_oe_o) else $error("first pulse not ones");
  a_write_data: assert property (s_second |-> mem_data_o == wdata_q)
    else $error("second pulse data wrong");
  a_gate_high: assert property (prog_supply_o |-> gate_n_o)
    else $error("gate low during pulse");
  a_pins_held: assert property (prog_supply_o |-> !select_n_o &&
    (gate_hv_o || mem_addr_o == addr_q)) else $error("pins not held");
  a_data_stable: assert property (prog_supply_o && $past(prog_supply_o) |->
    $stable(mem_data_o)) else $error("data moved in pulse");
  a_chip_ones: assert property (gate_hv_o |-> op_q == 2'h3 &&
    mem_data_o == 8'hFF && mem_data_oe_o) else $error("chip erase pins wrong");
  a_ready_wait: assert property (prog_supply_o && USE_WAIT |-> !ready_o)
    else $error("ready high in write");
  a_done_after: assert property (done_o |-> !prog_supply_o &&
    falls == (op_q == 2'h1 ? 2'h2 : 2'h1)) else $error("done too early");
  a_read_gate: assert property (rvalid_o |->
    $past(!select_n_o && !gate_n_o)) else $error("read without gating");
  a_no_clash: assert property (!gate_n_o |->
    !select_n_o && !mem_data_oe_o) else $error("gate low while driving");
endmodule : eeprom_ctrl_chk
bind eeprom_ctrl eeprom_ctrl_chk #(.PULSE_CYC(PULSE_CYC),
  .CHIP_ERASE_CYC(CHIP_ERASE_CYC), .USE_WAIT(USE_WAIT)) chk (.clk_i, .rst_i,
  .req_i, .op_i, .addr_i, .wdata_i, .ready_o, .busy_o, .rvalid_o, .done_o,
  .mem_addr_o, .mem_data_o, .mem_data_oe_o, .select_n_o, .gate_n_o,
  .gate_hv_o, .prog_supply_o);

// [verification/eeprom_ctrl_tb.sv]
// Self-checking bench for the memory controller.
// Assumes the memory model and the bound checker are compiled.
`timescale 1ns/10ps
module eeprom_ctrl_tb;
  localparam int LIM = 2000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [1:0] op_i = 2'h0;
  logic [10:0] addr_i = 11'h000;
  logic [7:0] wdata_i = 8'h00;
  logic ready_o, busy_o, rvalid_o, done_o, mem_data_oe_o, m_oe;
  logic select_n_o, gate_n_o, gate_hv_o, prog_supply_o;
  logic [7:0] rdata_o, mem_data_o, m_data, rv;
  logic [10:0] mem_addr_o;
  wire logic [7:0] bus = mem_data_oe_o ? mem_data_o : m_data;
  int err_count = 0;
  int total_checks = 0;
  int bad;
  always #5 clk_i = ~clk_i;
  eeprom_ctrl #(.PULSE_CYC(40), .CHIP_ERASE_CYC(50)) uut (.clk_i, .rst_i,
    .req_i, .op_i, .addr_i, .wdata_i, .ready_o, .busy_o, .rdata_o, .rvalid_o,
    .done_o, .mem_addr_o, .mem_data_i(bus), .mem_data_o, .mem_data_oe_o,
    .select_n_o, .gate_n_o, .gate_hv_o, .prog_supply_o);
  eeprom_mem_model #(.PULSE_MIN_NS(400.0)) mdl (.addr_i(mem_addr_o),
    .data_i(bus), .select_n_i(select_n_o), .gate_n_i(gate_n_o),
    .gate_hv_i(gate_hv_o), .prog_i(prog_supply_o), .data_o(m_data),
    .oe_o(m_oe), .bad_o(bad));
  task automatic end_of_test();
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk
  task automatic do_op(input logic [1:0] op, input logic [10:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    while (!(ready_o === 1'b1 && busy_o === 1'b0) && n < LIM)
    begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    req_i <= 1'b1;
    op_i <= op;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    req_i <= 1'b0;
    while (rvalid_o !== 1'b1 && done_o !== 1'b1 && n < LIM)
    begin
      @(negedge clk_i);
      n++;
    end
    rv = rdata_o;
    if (n >= LIM)
    begin
      err_count++;
      end_of_test();
    end
  endtask : do_op
  task automatic t_read(input logic [10:0] a, input logic [7:0] e);
    do_op(2'h0, a, 8'h00);
    chk("rdata", e, rv);
  endtask : t_read
  task automatic t_idle();
    chk("select_n", 8'h01, {7'h00, select_n_o});
    chk("idle_pins", 8'h00, {5'h00, gate_hv_o, prog_supply_o, mem_data_oe_o});
  endtask : t_idle
  task automatic t_reads();
    t_read(11'h000, 8'h3C);
    t_read(11'h7FF, 8'hC3);
    t_read(11'h123, 8'h1F);
  endtask : t_reads
  task automatic t_write();
    do_op(2'h1, 11'h005, 8'hA5);
    chk("bad_pulses", 8'h00, bad[7:0]);
    t_read(11'h005, 8'hA5);
    t_read(11'h004, 8'h38);
    t_read(11'h006, 8'h3A);
  endtask : t_write
  task automatic t_erase();
    do_op(2'h2, 11'h00A, 8'h00);
    chk("bad_pulses", 8'h00, bad[7:0]);
    t_read(11'h00A, 8'hFF);
    t_read(11'h00B, 8'h37);
  endtask : t_erase
  task automatic t_chip();
    do_op(2'h3, 11'h000, 8'hFF);
    t_read(11'h005, 8'hFF);
    t_read(11'h7FF, 8'hFF);
  endtask : t_chip
  always @(negedge clk_i)
    if (mem_data_oe_o === 1'b1 && m_oe === 1'b1)
    begin
      $display("wrong value bus_drivers expected 1 seen 2");
      err_count++;
    end
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    t_idle();
    t_reads();
    t_write();
    t_erase();
    t_chip();
    end_of_test();
  end
endmodule : eeprom_ctrl_tb

// [verification/eeprom_mem_model.sv]
// Behavioural model of the memory seen from its pins.
// Assumes times in ns; the bench resolves the data lines.
`timescale 1ns/10ps
module eeprom_mem_model
#(
  parameter real PULSE_MIN_NS = 9.0e6,
  parameter real PULSE_MAX_NS = 7.0e7
)
(
  input wire logic [10:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic select_n_i,
  input wire logic gate_n_i,
  input wire logic gate_hv_i,
  input wire logic prog_i,
  output logic [7:0] data_o,
  output logic oe_o,
  output int bad_o
);
  logic [7:0] mem [0:2047];
  realtime t_sel = 0.0;
  realtime t_gate = 0.0;
  realtime t_addr = 0.0;
  realtime t_rise = 0.0;
  realtime width;
  initial
  begin
    data_o = 8'h00;
    oe_o = 1'b0;
    bad_o = 0;
    for (int i = 0; i < 2048; i++)
      mem[i] = i[7:0] ^ 8'h3C;
  end
  always @(negedge select_n_i) t_sel = $realtime;
  always @(negedge gate_n_i) t_gate = $realtime;
  always @(addr_i) t_addr = $realtime;
  always @(posedge prog_i) t_rise = $realtime;
  always #1
  begin
    oe_o = !select_n_i && !gate_n_i && !prog_i;
    if (oe_o && $realtime >= t_sel + 250.0 && $realtime >= t_addr + 250.0
      && $realtime >= t_gate + 100.0)
      data_o = mem[addr_i];
    else
      data_o = ~data_o;
  end
  always @(negedge prog_i)
  begin
    width = $realtime - t_rise;
    if (!select_n_i && gate_hv_i)
      for (int i = 0; i < 2048; i++)
        mem[i] = 8'hFF;
    else if (!select_n_i && gate_n_i)
    begin
      if (width < PULSE_MIN_NS || width > PULSE_MAX_NS)
        bad_o++;
      mem[addr_i] = (data_i === 8'hFF) ? 8'hFF : mem[addr_i] & data_i;
    end
  end
endmodule : eeprom_mem_model
